// ==== verilog/tpc_pkg.sv ====
package tpc_pkg;

   // Timing
   localparam int CLK_PERIOD_NS      = 10;
   localparam int RESET_CMD_MIN_NS   = 100;
   localparam int RESET_CMD_CYCLES   = (RESET_CMD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int IRQ_PULSE_NS       = 200;
   localparam int IRQ_PULSE_CYCLES   = IRQ_PULSE_NS / CLK_PERIOD_NS;
   localparam int ACK_MIN_NS         = 250;
   localparam int CNT_W              = 5;

   // Register indices; byte address is four times the index
   localparam logic [13:0] IDX_MCFG1   = 14'h0000;
   localparam logic [13:0] IDX_MSTAT   = 14'h0001;
   localparam logic [13:0] IDX_OPSTAT  = 14'h0002;
   localparam logic [13:0] IDX_SWBITS  = 14'h0003;

   // Master configuration 1 fields
   localparam int MCFG1_IRQ_LEVEL = 0;
   localparam logic [31:0] MCFG1_RESET = 32'h0000_0000;

   // Master status fields
   localparam int MSTAT_READY     = 0;
   localparam int MSTAT_TEST      = 1;
   localparam int MSTAT_BUSY_ONLY = 2;
   localparam int MSTAT_MR_LEVEL  = 3;

   // Operational status fields
   localparam int OPSTAT_ADDR_LSB = 0;
   localparam int OPSTAT_PARITY   = 5;
   localparam int OPSTAT_LOCK     = 6;
   localparam int OPSTAT_PAR_ERR  = 7;

   // Status word bits fields
   localparam int SWBITS_SSF      = 0;
   localparam int SWBITS_TRIG     = 1;
   localparam int SWBITS_IRQ      = 2;
   localparam logic [31:0] SWBITS_RESET = 32'h0000_0000;

   // Positions in the synchronised pin vector
   localparam int PIN_W    = 17;
   localparam int PIN_MR   = 0;
   localparam int PIN_TRIG = 1;
   localparam int PIN_BUSY = 2;
   localparam int PIN_LOCK = 3;
   localparam int PIN_PAR  = 4;
   localparam int PIN_SSF  = 5;
   localparam int PIN_ACK  = 6;
   localparam int PIN_BO   = 7;
   localparam int PIN_TEST = 8;
   localparam int PIN_CE_N = 9;
   localparam int PIN_SCK  = 10;
   localparam int PIN_SI   = 11;
   localparam int PIN_ADDR = 12;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;

endpackage : tpc_pkg

// ==== verilog/tpc_sync.sv ====
`timescale 1ns/100ps
module tpc_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Data
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   // First stage is read by the second stage only
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule : tpc_sync

// ==== verilog/tpc_top.sv ====
// Notes on behaviour
// - Trigger input active high, level exported
// - Busy-only mode pin sampled at reset
// - Busy-only: busy status, no data, no interrupts
// - Lock pin captured on master reset rise
// - Locked: host writes to address ignored
// - Unlocked: host rewrites address, parity, lock
// - Reset command output low at least 100ns
// - Subsystem fail is pin OR register bit
// - Interrupt output asserted per enabled event
// - Config bit picks pulse or level interrupt
// - Level held until acknowledge pulse, 250ns min
// - Acknowledge ignored in pulse mode
// - Address captured at reset; register is active
// - Byte-order pin picks serial byte order
// - Test pin runs self-test
// - Serial port slave, gated by chip select
// - Serial output released when not shifting
// - Not ready: reads return master status
// - Master reset active low, capture on rise
`timescale 1ns/100ps
module tpc_top (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Device pins
   input  wire logic        master_reset_n,
   input  wire logic        controller_trigger_in,
   input  wire logic        busy_only_mode_in,
   input  wire logic        address_lock_in,
   input  wire logic [4:0]  terminal_address_in,
   input  wire logic        terminal_address_parity_in,
   input  wire logic        subsystem_fail_in,
   input  wire logic        interrupt_ack_in,
   input  wire logic        byte_order_select,
   input  wire logic        test_enable_in,
   output logic             irq_n_o,
   output logic             irq_n_oe,
   output logic             reset_cmd_seen_n_o,
   output logic             reset_cmd_seen_n_oe,
   output logic             ready,
   // Serial host port
   input  wire logic        spi_ce_n,
   input  wire logic        spi_sck,
   input  wire logic        spi_si,
   output logic             spi_so,
   output logic             spi_so_oe,
   // Terminal core side
   input  wire logic        irq_event,
   input  wire logic        reset_terminal_mode_command,
   input  wire logic        init_busy,
   input  wire logic [15:0] spi_tx_word,
   input  wire logic        spi_tx_en,
   output logic             trigger_level,
   output logic             busy_only,
   output logic             status_subsystem_fail,
   output logic      [4:0]  terminal_address,
   output logic             terminal_enable,
   output logic             self_test_run,
   output logic      [15:0] spi_rx_word,
   output logic             spi_rx_valid
);

   function automatic logic [31:0] reg_addr(input logic [13:0] idx);
      reg_addr = {16'h0000, idx, 2'b00};
   endfunction : reg_addr

   // Serial order word to storage order and back; the swap is its own inverse
   function automatic logic [15:0] order_word(input logic [15:0] w, input logic big);
      order_word = big ? w : {w[7:0], w[15:8]};
   endfunction : order_word

   // Pin synchronisers
   logic [tpc_pkg::PIN_W-1:0] pins_s;

   tpc_sync #(.WIDTH(tpc_pkg::PIN_W)) u_sync (
      .clk      (hclk),
      .rst_n    (hresetn),
      .async_in ({terminal_address_in, spi_si, spi_sck, spi_ce_n, test_enable_in,
                  byte_order_select, interrupt_ack_in, subsystem_fail_in,
                  terminal_address_parity_in, address_lock_in, busy_only_mode_in,
                  controller_trigger_in, master_reset_n}),
      .sync_out (pins_s)
   );

   wire mr_s   = pins_s[tpc_pkg::PIN_MR];
   wire trig_s = pins_s[tpc_pkg::PIN_TRIG];
   wire ack_s  = pins_s[tpc_pkg::PIN_ACK];
   wire ssf_s  = pins_s[tpc_pkg::PIN_SSF];
   wire bo_s   = pins_s[tpc_pkg::PIN_BO];
   wire test_s = pins_s[tpc_pkg::PIN_TEST];
   wire ce_s   = ~pins_s[tpc_pkg::PIN_CE_N];
   wire sck_s  = pins_s[tpc_pkg::PIN_SCK];
   wire si_s   = pins_s[tpc_pkg::PIN_SI];

   // Edge detectors on synchronised levels
   logic mr_prev_q, ack_prev_q, sck_prev_q;
   wire  mr_rise  = mr_s & ~mr_prev_q;
   wire  ack_rise = ack_s & ~ack_prev_q;
   wire  sck_rise = sck_s & ~sck_prev_q;
   wire  sck_fall = ~sck_s & sck_prev_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mr_prev_q  <= 1'b0;
         ack_prev_q <= 1'b0;
         sck_prev_q <= 1'b0;
      end else begin
         mr_prev_q  <= mr_s;
         ack_prev_q <= ack_s;
         sck_prev_q <= sck_s;
      end
   end

   // AHB-Lite address phase capture; zero wait state slave
   logic        wr_pend_q;
   logic [31:0] wr_addr_q;
   logic [31:0] mcfg1_q, swbits_q;
   logic [4:0]  addr_q;
   logic        par_q, lock_q, busy_only_q;

   wire  access   = hsel & hready & (htrans == tpc_pkg::HTRANS_NONSEQ);
   wire  rd_req   = access & ~hwrite;
   wire  wr_req   = access & hwrite & (hsize == tpc_pkg::HSIZE_WORD) & ready;
   wire  irq_lvl  = mcfg1_q[tpc_pkg::MCFG1_IRQ_LEVEL];
   wire  par_err  = ~(^{addr_q, par_q});
   wire  wr_op    = wr_pend_q & (wr_addr_q == reg_addr(tpc_pkg::IDX_OPSTAT));
   wire  irq_act;

   wire [31:0] mstat_v = {28'h0000000, mr_s, busy_only_q, test_s, ready};
   wire [31:0] opstat_v = {24'h000000, par_err, lock_q, par_q, addr_q};
   wire [31:0] swbits_v = {29'h00000000, irq_act, trig_s, swbits_q[tpc_pkg::SWBITS_SSF]};

   // Not ready: every read answers with master status
   wire [31:0] rd_data =
      !ready                                ? mstat_v :
      haddr == reg_addr(tpc_pkg::IDX_MCFG1)  ? mcfg1_q :
      haddr == reg_addr(tpc_pkg::IDX_MSTAT)  ? mstat_v :
      haddr == reg_addr(tpc_pkg::IDX_OPSTAT) ? opstat_v :
      haddr == reg_addr(tpc_pkg::IDX_SWBITS) ? swbits_v : 32'h0000_0000;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 32'h0000_0000;
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
      end else begin
         wr_pend_q <= wr_req;
         wr_addr_q <= haddr;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (rd_req) begin
            hrdata <= rd_data;
         end
      end
   end

   // Writable registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mcfg1_q  <= tpc_pkg::MCFG1_RESET;
         swbits_q <= tpc_pkg::SWBITS_RESET;
      end else if (wr_pend_q) begin
         if (wr_addr_q == reg_addr(tpc_pkg::IDX_MCFG1)) begin
            mcfg1_q <= {31'h00000000, hwdata[tpc_pkg::MCFG1_IRQ_LEVEL]};
         end
         if (wr_addr_q == reg_addr(tpc_pkg::IDX_SWBITS)) begin
            swbits_q <= {31'h00000000, hwdata[tpc_pkg::SWBITS_SSF]};
         end
      end
   end

   // Straps caught on master reset rise; register then owns the address
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_q      <= 5'h00;
         par_q       <= 1'b0;
         lock_q      <= 1'b0;
         busy_only_q <= 1'b0;
      end else if (mr_rise) begin
         addr_q      <= pins_s[tpc_pkg::PIN_ADDR +: 5];
         par_q       <= pins_s[tpc_pkg::PIN_PAR];
         lock_q      <= pins_s[tpc_pkg::PIN_LOCK];
         busy_only_q <= pins_s[tpc_pkg::PIN_BUSY];
      end else if (wr_op && !lock_q) begin
         addr_q <= hwdata[tpc_pkg::OPSTAT_ADDR_LSB +: 5];
         par_q  <= hwdata[tpc_pkg::OPSTAT_PARITY];
         lock_q <= hwdata[tpc_pkg::OPSTAT_LOCK];
      end
   end

   // Interrupt output; busy-only mode suppresses events
   logic             irq_q;
   logic [tpc_pkg::CNT_W-1:0] irq_cnt_q;
   wire  irq_set   = irq_event & ~busy_only_q;
   wire  irq_clr   = irq_lvl & ack_rise;
   wire  pulse_end = ~irq_lvl & (irq_cnt_q == tpc_pkg::CNT_W'(1));
   assign irq_act  = irq_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_q     <= 1'b0;
         irq_cnt_q <= '0;
      end else if (irq_set) begin
         irq_q     <= 1'b1;
         irq_cnt_q <= tpc_pkg::CNT_W'(tpc_pkg::IRQ_PULSE_CYCLES);
      end else if (irq_clr || pulse_end) begin
         irq_q     <= 1'b0;
         irq_cnt_q <= '0;
      end else if (irq_cnt_q != '0) begin
         irq_cnt_q <= irq_cnt_q - 1'b1;
      end
   end

   // Reset command pulse; only the bus reset clears it, master reset does not
   logic [tpc_pkg::CNT_W-1:0] rcmd_cnt_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rcmd_cnt_q <= '0;
      end else if (reset_terminal_mode_command) begin
         rcmd_cnt_q <= tpc_pkg::CNT_W'(tpc_pkg::RESET_CMD_CYCLES);
      end else if (rcmd_cnt_q != '0) begin
         rcmd_cnt_q <= rcmd_cnt_q - 1'b1;
      end
   end

   // Serial slave port, mode 0: sample on rising, shift on falling
   logic [15:0] rx_sh_q, tx_sh_q;
   logic [3:0]  bit_cnt_q;
   wire  [15:0] rx_next = {rx_sh_q[14:0], si_s};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_sh_q      <= 16'h0000;
         tx_sh_q      <= 16'h0000;
         bit_cnt_q    <= 4'h0;
         spi_rx_word  <= 16'h0000;
         spi_rx_valid <= 1'b0;
      end else begin
         spi_rx_valid <= 1'b0;
         if (!ce_s) begin
            bit_cnt_q <= 4'h0;
            tx_sh_q   <= order_word(spi_tx_word, bo_s);
         end else if (sck_rise) begin
            rx_sh_q   <= rx_next;
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == 4'hf) begin
               spi_rx_word  <= order_word(rx_next, bo_s);
               spi_rx_valid <= 1'b1;
               tx_sh_q      <= order_word(spi_tx_word, bo_s);
            end
         end else if (sck_fall && bit_cnt_q != 4'h0) begin
            tx_sh_q <= {tx_sh_q[14:0], 1'b0};
         end
      end
   end

   // Registered pins and core outputs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_n_o               <= 1'b1;
         irq_n_oe              <= 1'b0;
         reset_cmd_seen_n_o    <= 1'b1;
         reset_cmd_seen_n_oe   <= 1'b0;
         ready                 <= 1'b0;
         spi_so                <= 1'b0;
         spi_so_oe             <= 1'b0;
         trigger_level         <= 1'b0;
         busy_only             <= 1'b0;
         status_subsystem_fail <= 1'b0;
         terminal_address      <= 5'h00;
         terminal_enable       <= 1'b0;
         self_test_run         <= 1'b0;
      end else begin
         irq_n_o               <= ~irq_q;
         irq_n_oe              <= irq_q;
         reset_cmd_seen_n_o    <= rcmd_cnt_q == '0;
         reset_cmd_seen_n_oe   <= rcmd_cnt_q != '0;
         ready                 <= mr_s & ~test_s & ~init_busy;
         spi_so                <= tx_sh_q[15];
         spi_so_oe             <= ce_s & spi_tx_en;
         trigger_level         <= trig_s;
         busy_only             <= busy_only_q;
         status_subsystem_fail <= ssf_s | swbits_q[tpc_pkg::SWBITS_SSF];
         terminal_address      <= addr_q;
         terminal_enable       <= ~par_err;
         self_test_run         <= test_s;
      end
   end

   // Checks
   property p_rcmd_width;
      @(posedge hclk) disable iff (!hresetn)
      $rose(reset_cmd_seen_n_oe) |-> reset_cmd_seen_n_oe[*8] ##1 reset_cmd_seen_n_oe;
   endproperty
   a_rcmd_width: assert property (p_rcmd_width) else $error("reset cmd pulse short");

   property p_lock_hold;
      @(posedge hclk) disable iff (!hresetn)
      wr_op && lock_q && !mr_rise |=> $stable(addr_q) && lock_q;
   endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("locked address changed");

   property p_unlock_write;
      @(posedge hclk) disable iff (!hresetn)
      wr_op && !lock_q && !mr_rise |=> addr_q == $past(hwdata[4:0]);
   endproperty
   a_unlock_write: assert property (p_unlock_write) else $error("address not written");

   property p_level_hold;
      @(posedge hclk) disable iff (!hresetn)
      irq_q && irq_lvl && !ack_rise |=> irq_q;
   endproperty
   a_level_hold: assert property (p_level_hold) else $error("level irq dropped");

   property p_ack_clear;
      @(posedge hclk) disable iff (!hresetn)
      irq_q && irq_lvl && ack_rise && !irq_set |=> !irq_q ##1 irq_n_o;
   endproperty
   a_ack_clear: assert property (p_ack_clear) else $error("ack did not release irq");

   property p_pulse_len;
      @(posedge hclk) disable iff (!hresetn)
      $rose(irq_q) && !irq_lvl |-> irq_q[*8];
   endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("pulse cut short");

   property p_ssf;
      @(posedge hclk) disable iff (!hresetn)
      ##1 status_subsystem_fail == ($past(ssf_s) | $past(swbits_q[0]));
   endproperty
   a_ssf: assert property (p_ssf) else $error("subsystem fail mismatch");

   property p_busy_read;
      @(posedge hclk) disable iff (!hresetn)
      rd_req && !ready |=> hrdata == $past(mstat_v);
   endproperty
   a_busy_read: assert property (p_busy_read) else $error("not-ready read wrong");

   property p_busy_no_irq;
      @(posedge hclk) disable iff (!hresetn)
      busy_only_q && !irq_q |=> !irq_q;
   endproperty
   a_busy_no_irq: assert property (p_busy_no_irq) else $error("irq in busy-only");

   property p_so_release;
      @(posedge hclk) disable iff (!hresetn)
      !ce_s |=> !spi_so_oe;
   endproperty
   a_so_release: assert property (p_so_release) else $error("so driven idle");

   c_level_ack: cover property (@(posedge hclk) disable iff (!hresetn) irq_clr && irq_q);
   c_rcmd: cover property (@(posedge hclk) disable iff (!hresetn) $fell(reset_cmd_seen_n_oe));
   c_rx_word: cover property (@(posedge hclk) disable iff (!hresetn) spi_rx_valid);

endmodule : tpc_top

// ==== test/tpc_spi_host.sv ====
`timescale 1ns/100ps
module tpc_spi_host (
   // Serial lines
   output logic      spi_ce_n,
   output logic      spi_sck,
   output logic      spi_si,
   input  wire logic spi_so,
   input  wire logic spi_so_oe
);
   logic so_last;
   logic so_line;

   // No pull on the line, so a released output reads as the inverse of the last bit
   assign so_line = spi_so_oe ? spi_so : ~so_last;

   initial begin
      spi_ce_n = 1'b1;
      spi_sck  = 1'b0;
      spi_si   = 1'b0;
      so_last  = 1'b0;
   end

   // Mode 0 master; sck stands still outside frames, 80 ns period
   task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
      spi_ce_n = 1'b0;
      #40;
      for (int i = 15; i >= 0; i--) begin
         spi_si = tx[i];
         #40;
         spi_sck = 1'b1;
         rx[i]   = so_line;
         so_last = so_line;
         #40;
         spi_sck = 1'b0;
      end
      #40;
      spi_ce_n = 1'b1;
      spi_si   = ~spi_si;
   endtask : xfer
endmodule : tpc_spi_host

// ==== test/testbench.sv ====
`timescale 1ns/100ps
module testbench;
   localparam logic [31:0] A_CFG  = 32'h0;
   localparam logic [31:0] A_STAT = 32'h4;
   localparam logic [31:0] A_OP   = 32'h8;
   localparam logic [31:0] A_SW   = 32'hc;

   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        master_reset_n, controller_trigger_in, busy_only_mode_in, address_lock_in;
   logic [4:0]  terminal_address_in, terminal_address;
   logic        terminal_address_parity_in, subsystem_fail_in, interrupt_ack_in;
   logic        byte_order_select, test_enable_in, irq_n_o, irq_n_oe, ready;
   logic        reset_cmd_seen_n_o, reset_cmd_seen_n_oe;
   logic        spi_ce_n, spi_sck, spi_si, spi_so, spi_so_oe;
   logic        irq_event, reset_terminal_mode_command, init_busy, spi_tx_en;
   logic [15:0] spi_tx_word, spi_rx_word, hrx;
   logic        trigger_level, busy_only, status_subsystem_fail, terminal_enable;
   logic        self_test_run, spi_rx_valid;
   int          err_count, comparisons, cycles, cnt;

   tpc_top DUT (.hready(hreadyout), .*);

   tpc_spi_host host (
      .spi_ce_n  (spi_ce_n),
      .spi_sck   (spi_sck),
      .spi_si    (spi_si),
      .spi_so    (spi_so),
      .spi_so_oe (spi_so_oe)
   );

   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim

   always @(posedge hclk) begin
      cycles++;
      // Whole run needs well under a thousand cycles
      if (cycles == 20000) begin
         err_count++;
         end_sim();
      end
   end

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic chk1(input string nm, input logic exp, input logic got);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL %s expected %b seen %b", nm, exp, got);
      end
   endtask : chk1

   // Entered just after a rising edge; waits on hready, never on a fixed count
   task automatic ahb(input logic wr, input logic [31:0] a, d, output logic [31:0] r);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= tpc_pkg::HTRANS_NONSEQ;
      hwrite <= wr;
      hsize  <= tpc_pkg::HSIZE_WORD;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : ahb

   task automatic wr(input logic [31:0] a, d);
      logic [31:0] r;
      ahb(1'b1, a, d, r);
   endtask : wr

   task automatic rd(input string nm, input logic [31:0] a, exp);
      logic [31:0] r;
      ahb(1'b0, a, 32'h0, r);
      chk(nm, exp, r);
   endtask : rd

   task automatic mrst(input logic lk, input logic [4:0] ad, input logic p, b);
      master_reset_n             <= 1'b0;
      address_lock_in            <= lk;
      terminal_address_in        <= ad;
      terminal_address_parity_in <= p;
      busy_only_mode_in          <= b;
      repeat (6) @(posedge hclk);
      master_reset_n <= 1'b1;
      repeat (8) @(posedge hclk);
   endtask : mrst

   task automatic pulse_evt;
      irq_event <= 1'b1;
      @(posedge hclk);
      irq_event <= 1'b0;
   endtask : pulse_evt

   task automatic count_irq(input int n);
      cnt = 0;
      repeat (n) begin
         @(posedge hclk);
         if (irq_n_oe === 1'b1 && irq_n_o === 1'b0)
            cnt++;
      end
   endtask : count_irq

   function automatic logic [15:0] ser(input logic [15:0] w, input logic bo);
      return bo ? w : {w[7:0], w[15:8]};
   endfunction : ser

   initial begin
      {hresetn, hsel, hwrite, haddr, hwdata, htrans, hsize} = '0;
      {master_reset_n, controller_trigger_in, busy_only_mode_in, address_lock_in} = '0;
      {terminal_address_in, terminal_address_parity_in, subsystem_fail_in} = '0;
      {interrupt_ack_in, byte_order_select, test_enable_in, irq_event} = '0;
      {reset_terminal_mode_command, init_busy, spi_tx_en, spi_tx_word} = '0;
      {err_count, comparisons, cycles} = '0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      mrst(1'b1, 5'h15, 1'b0, 1'b0);
      chk("addr", 32'h15, {27'h0, terminal_address});
      chk1("terminal enable", 1'b1, terminal_enable);
      chk1("hresp okay", 1'b0, hresp);
      rd("opstat", A_OP, 32'h55);
      terminal_address_in <= 5'h0a;
      wr(A_OP, 32'h2a);
      rd("opstat locked", A_OP, 32'h55);
      chk("addr held", 32'h15, {27'h0, terminal_address});
      rd("mstat", A_STAT, 32'h9);
      rd("unmapped", 32'h40, 32'h0);
      mrst(1'b0, 5'h03, 1'b1, 1'b0);
      rd("opstat", A_OP, 32'h23);
      wr(A_OP, 32'h6a);
      rd("opstat open", A_OP, 32'h6a);
      chk("addr new", 32'h0a, {27'h0, terminal_address});
      wr(A_OP, 32'h23);
      rd("opstat relocked", A_OP, 32'h6a);
      init_busy <= 1'b1;
      repeat (4) @(posedge hclk);
      chk1("ready", 1'b0, ready);
      wr(A_SW, 32'h1);
      rd("busy read", A_OP, 32'h8);
      init_busy      <= 1'b0;
      test_enable_in <= 1'b1;
      repeat (5) @(posedge hclk);
      chk1("self test", 1'b1, self_test_run);
      rd("test read", A_SW, 32'ha);
      test_enable_in <= 1'b0;
      repeat (5) @(posedge hclk);
      rd("swbits", A_SW, 32'h0);
      controller_trigger_in <= 1'b1;
      subsystem_fail_in     <= 1'b1;
      repeat (5) @(posedge hclk);
      chk1("trigger", 1'b1, trigger_level);
      chk1("ssf pin", 1'b1, status_subsystem_fail);
      rd("swbits trig", A_SW, 32'h2);
      controller_trigger_in <= 1'b0;
      subsystem_fail_in     <= 1'b0;
      wr(A_SW, 32'h1);
      repeat (5) @(posedge hclk);
      chk1("ssf reg", 1'b1, status_subsystem_fail);
      wr(A_SW, 32'h0);
      repeat (5) @(posedge hclk);
      chk1("ssf off", 1'b0, status_subsystem_fail);
      // Master reset lands inside the pulse and must not cut it short
      reset_terminal_mode_command <= 1'b1;
      @(posedge hclk);
      reset_terminal_mode_command <= 1'b0;
      master_reset_n              <= 1'b0;
      cnt = 0;
      repeat (30) begin
         @(posedge hclk);
         if (reset_cmd_seen_n_oe === 1'b1 && reset_cmd_seen_n_o === 1'b0)
            cnt++;
      end
      chk("reset cmd width", 32'd10, cnt);
      master_reset_n <= 1'b1;
      repeat (8) @(posedge hclk);
      pulse_evt();
      interrupt_ack_in <= 1'b1;
      count_irq(35);
      interrupt_ack_in <= 1'b0;
      chk1("irq pulse", 1'b1, cnt >= 19 && cnt <= 21);
      wr(A_CFG, 32'h1);
      rd("cfg1", A_CFG, 32'h1);
      pulse_evt();
      // First sample sees the pin flop before it takes the new flag
      count_irq(41);
      chk("irq level", 32'd40, cnt);
      rd("irq flag", A_SW, 32'h4);
      interrupt_ack_in <= 1'b1;
      repeat (25) @(posedge hclk);
      interrupt_ack_in <= 1'b0;
      chk1("irq released", 1'b0, irq_n_oe);
      mrst(1'b0, 5'h03, 1'b1, 1'b1);
      chk1("busy only", 1'b1, busy_only);
      rd("mstat busy", A_STAT, 32'hd);
      pulse_evt();
      count_irq(10);
      chk("busy irq", 32'd0, cnt);
      mrst(1'b0, 5'h03, 1'b1, 1'b0);
      spi_tx_word <= 16'ha5c3;
      spi_tx_en   <= 1'b1;
      for (int bo = 0; bo < 2; bo++) begin
         byte_order_select <= bo[0];
         repeat (4) @(posedge hclk);
         #3;
         host.xfer(ser(16'h1234, bo[0]), hrx);
         repeat (5) @(posedge hclk);
         chk("rx word", 32'h1234, {16'h0, spi_rx_word});
         chk("tx serial", {16'h0, ser(16'ha5c3, bo[0])}, {16'h0, hrx});
         chk1("so released", 1'b0, spi_so_oe);
      end
      end_sim();
   end
endmodule : testbench
